/* File: service_timer_pkg.sv */
package service_timer_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] SERVICE_OFFSET = 12'h000;
  localparam logic [11:0] CONFIG_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam logic [11:0] IDLE_COUNT_OFFSET = 12'h00c;

  // Service register fields
  localparam int WINDOW_MSB = 7;
  localparam int WINDOW_LSB = 6;
  localparam int KEY_MSB = 5;
  localparam int KEY_LSB = 1;
  localparam int MONITOR_BIT = 0;
  localparam logic [4:0] SERVICE_KEY = 5'h0c;

  // Configuration register fields
  localparam int TIMER_DISABLE_BIT = 2;
  localparam int RC_SINGLE_PIN_BIT = 3;
  localparam int CLOCK_DELAY_BIT = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Status register fields
  localparam int STAT_TIMER_ERR_BIT = 0;
  localparam int STAT_MONITOR_ERR_BIT = 1;
  localparam int STAT_FIRST_DONE_BIT = 2;
  localparam int STAT_PENDING_BIT = 3;
  localparam int STAT_PIN_BIT = 4;

  // Values after reset
  localparam logic [1:0] WINDOW_RESET = 2'h3;
  localparam logic MONITOR_RESET = 1'b1;

  // Counts in instruction cycles
  localparam logic [16:0] LOWER_LIMIT = 17'h00800;
  localparam logic [16:0] BASE_UPPER = 17'h02000;
  localparam logic [5:0] RELEASE_HOLD = 6'h18;
  localparam int IDLE_TOGGLE_BIT = 12;

  // Timing
  localparam int PCLK_PERIOD_NS = 10;
  localparam int MONITOR_GAP_NS = 1000000;

  typedef enum {
    ST_ARMED,
    ST_HOLD,
    ST_WAIT_HIGH
  } timer_state_t;

  typedef struct packed {
    logic [1:0] window;
    logic monitor_en;
  } service_cfg_t;

endpackage

/* File: windowed_service_timer_clock_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Service register: window, key, monitor enable
// - Key must be 01100, else error
// - Lower window bound fixed at 2048 cycles
// - Window select gives 8k/16k/32k/64k upper
// - Bit 0 enables the clock monitor
// - Option bit 2 low enables timer output
// - Inhibited in reset, max window, monitor on
// - Only first keyed write loads settings
// - Later writes compared with stored fields
// - Full match restarts, any mismatch errors
// - Output active low, weak pull-up otherwise
// - Hold low 16-32 cycles after pin low
// - Service writes ignored while output active
// - Monitor error drives pin, released after recovery
// - Monitor passes above 10 kHz, fails below 10 Hz
// - Key field reads back as zero
// - Halt and idle stop timer, not monitor
// - After halt resume or reload per option
// - Leaving idle performs a hardware service
// - First service accepted anywhere in 64k window
// - Pending flag set on bit twelve toggle
module windowed_service_timer_clock_monitor #(
  parameter int tc_div = 10,
  parameter int unsigned monitor_gap_cycles =
    service_timer_pkg::MONITOR_GAP_NS / service_timer_pkg::PCLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic clock_input_pin,
  // Open-drain error pin
  input wire logic port_g_bit1_pin_in,
  output logic port_g_bit1_pin_out,
  output logic port_g_bit1_pin_oe,
  output logic port_g_bit1_pullup_en,
  output logic timeout_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] upper_limit(input logic [1:0] sel);
    upper_limit = service_timer_pkg::BASE_UPPER << sel;
  endfunction

  service_timer_pkg::timer_state_t state;
  service_timer_pkg::service_cfg_t cfg;
  logic [7:0] config_option_register;
  logic first_done;
  logic [16:0] window_count;
  logic [5:0] hold_count;
  logic [5:0] mon_hold_count;
  logic [$clog2(tc_div+1)-1:0] div_count;
  logic tick;
  logic [31:0] gap_count;
  logic ck_prev;
  logic mon_fault;
  logic mon_err;
  logic halt_prev;
  logic idle_prev;
  logic [15:0] idle_counter;
  logic idle_counter_pending;
  logic timer_enabled;
  logic setup_ok;
  logic wr_access;
  logic svc_write;
  logic svc_match;
  logic svc_early;
  logic svc_error;
  logic timer_err;
  logic mapped;
  logic clear_pending;
  logic hardware_service;
  logic halt_exit;

  // A disabled timer silences the monitor output as well
  assign timer_enabled =
    !config_option_register[service_timer_pkg::TIMER_DISABLE_BIT];
  // Zero wait states, so every access ends after one cycle
  assign pready = 1'b1;
  assign mapped = (paddr == service_timer_pkg::SERVICE_OFFSET) ||
                  (paddr == service_timer_pkg::CONFIG_OFFSET) ||
                  (paddr == service_timer_pkg::STATUS_OFFSET) ||
                  (paddr == service_timer_pkg::IDLE_COUNT_OFFSET);
  assign pslverr = psel && penable && !mapped;
  assign setup_ok = psel && penable && mapped;
  assign wr_access = setup_ok && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle enable
  // One clock only; slower rates are one-cycle enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= '0;
    end else if (div_count == ($clog2(tc_div+1))'(tc_div - 1)) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end
  assign tick = (div_count == ($clog2(tc_div+1))'(tc_div - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Service decode
  // Writes during an error hold are dropped, not queued
  assign svc_write = wr_access &&
    (paddr == service_timer_pkg::SERVICE_OFFSET) && timer_enabled &&
    (state == service_timer_pkg::ST_ARMED) && !mon_err;
  assign svc_match =
    (pwdata[service_timer_pkg::KEY_MSB:service_timer_pkg::KEY_LSB] ==
     service_timer_pkg::SERVICE_KEY) &&
    (!first_done ||
     ((pwdata[service_timer_pkg::WINDOW_MSB:service_timer_pkg::WINDOW_LSB]
       == cfg.window) &&
      (pwdata[service_timer_pkg::MONITOR_BIT] == cfg.monitor_en)));
  // The very first service has no lower bound
  assign svc_early = first_done &&
    (window_count < service_timer_pkg::LOWER_LIMIT);
  assign svc_error = svc_write && (!svc_match || svc_early);
  // Exits are one-cycle pulses taken from the held levels
  assign halt_exit = halt_prev && !halt_mode;
  assign hardware_service = idle_prev && !idle_mode;

  // Stored window and monitor choice, loaded once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.window <= service_timer_pkg::WINDOW_RESET;
      cfg.monitor_en <= service_timer_pkg::MONITOR_RESET;
      first_done <= 1'b0;
    end else if (svc_write && !first_done && svc_match) begin
      cfg.window <=
        pwdata[service_timer_pkg::WINDOW_MSB:service_timer_pkg::WINDOW_LSB];
      cfg.monitor_en <= pwdata[service_timer_pkg::MONITOR_BIT];
      first_done <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_option_register <= service_timer_pkg::CONFIG_RESET;
    end else if (wr_access && paddr == service_timer_pkg::CONFIG_OFFSET) begin
      config_option_register <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_prev <= 1'b0;
      idle_prev <= 1'b0;
    end else begin
      halt_prev <= halt_mode;
      idle_prev <= idle_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window timer
  // An error wins over a good write or an exit in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= service_timer_pkg::ST_ARMED;
      window_count <= '0;
      hold_count <= '0;
    end else if (!timer_enabled) begin
      state <= service_timer_pkg::ST_ARMED;
      window_count <= '0;
      hold_count <= '0;
    end else begin
      case (state)
        service_timer_pkg::ST_ARMED: begin
          if (svc_error) begin
            state <= service_timer_pkg::ST_HOLD;
            hold_count <= '0;
          end else if (svc_write || hardware_service) begin
            window_count <= '0;
          end else if (halt_exit) begin
            // Resume only with single-pin RC and no clock delay
            if (!config_option_register[service_timer_pkg::RC_SINGLE_PIN_BIT]
                || config_option_register[service_timer_pkg::CLOCK_DELAY_BIT])
            begin
              window_count <= '0;
            end
          end else if (tick && !halt_mode && !idle_mode) begin
            if (window_count == upper_limit(cfg.window) - 17'h1) begin
              state <= service_timer_pkg::ST_HOLD;
              hold_count <= '0;
            end else begin
              window_count <= window_count + 17'h1;
            end
          end
        end
        service_timer_pkg::ST_HOLD: begin
          // Count starts once the pin level is really low
          if (tick && !port_g_bit1_pin_in) begin
            if (hold_count == service_timer_pkg::RELEASE_HOLD - 6'h1) begin
              state <= service_timer_pkg::ST_WAIT_HIGH;
            end else begin
              hold_count <= hold_count + 6'h1;
            end
          end
        end
        service_timer_pkg::ST_WAIT_HIGH: begin
          if (port_g_bit1_pin_in) begin
            state <= service_timer_pkg::ST_ARMED;
            window_count <= '0;
          end
        end
        default: begin
          state <= service_timer_pkg::ST_ARMED;
        end
      endcase
    end
  end
  assign timer_err = (state == service_timer_pkg::ST_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor: a missing edge for too long is a fault
  // The gap sets the slowest clock still accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_prev <= 1'b0;
      gap_count <= '0;
      mon_fault <= 1'b0;
    end else begin
      ck_prev <= clock_input_pin;
      if (clock_input_pin && !ck_prev) begin
        gap_count <= '0;
        mon_fault <= 1'b0;
      end else if (gap_count >= monitor_gap_cycles - 1) begin
        mon_fault <= 1'b1;
      end else begin
        gap_count <= gap_count + 32'h1;
      end
    end
  end

  // Monitor stays active in halt and idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_err <= 1'b0;
      mon_hold_count <= '0;
    end else if (!cfg.monitor_en || !timer_enabled) begin
      mon_err <= 1'b0;
      mon_hold_count <= '0;
    end else if (mon_fault) begin
      mon_err <= 1'b1;
      mon_hold_count <= '0;
    end else if (mon_err && tick) begin
      if (mon_hold_count == service_timer_pkg::RELEASE_HOLD - 6'h1) begin
        mon_err <= 1'b0;
      end else begin
        mon_hold_count <= mon_hold_count + 6'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle counter has no reset and keeps its count through reset
  always_ff @(posedge pclk) begin
    if (tick) begin
      idle_counter <= idle_counter + 16'h1;
    end
  end

  assign clear_pending = wr_access &&
    (paddr == service_timer_pkg::STATUS_OFFSET) &&
    pwdata[service_timer_pkg::STAT_PENDING_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_counter_pending <= 1'b0;
    end else if (tick &&
        (&idle_counter[service_timer_pkg::IDLE_TOGGLE_BIT-1:0])) begin
      // Set wins over a clear that lands in the same cycle
      idle_counter_pending <= 1'b1;
    end else if (clear_pending) begin
      idle_counter_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared open-drain error pin
  // Registered so that decode glitches never reach the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_out_n <= 1'b1;
      port_g_bit1_pin_oe <= 1'b0;
    end else begin
      timeout_out_n <= !(timer_err || mon_err);
      port_g_bit1_pin_oe <=
        timer_enabled && (timer_err || mon_err);
    end
  end
  assign port_g_bit1_pin_out = 1'b0;
  assign port_g_bit1_pullup_en = timer_enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Loaded in setup so the value stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        service_timer_pkg::SERVICE_OFFSET: begin
          prdata <= {24'h000000, cfg.window, 5'h00,
                     cfg.monitor_en};
        end
        service_timer_pkg::CONFIG_OFFSET: begin
          prdata <= {24'h000000, config_option_register};
        end
        service_timer_pkg::STATUS_OFFSET: begin
          prdata <= {27'h0000000, port_g_bit1_pin_in, idle_counter_pending,
                     first_done, mon_err, timer_err};
        end
        service_timer_pkg::IDLE_COUNT_OFFSET: begin
          prdata <= {16'h0000, idle_counter};
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: service_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none
module service_timer_props #(
  parameter int tc_div = 10
) (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and pin
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic port_g_bit1_pin_in,
  input wire logic port_g_bit1_pin_out,
  input wire logic port_g_bit1_pin_oe,
  input wire logic port_g_bit1_pullup_en,
  input wire logic timeout_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire oe = port_g_bit1_pin_oe;
  int low_cnt;
  // Counts from the pin level, so a slow external edge lengthens the hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 0;
    else if (oe && !port_g_bit1_pin_in) low_cnt <= low_cnt + 1;
    else low_cnt <= 0;
  end
  ////////////////////////////////////////
  sequence s_bad_key;
    acc && pwrite && paddr == 12'h000 &&
      pwdata[5:1] != service_timer_pkg::SERVICE_KEY && timeout_out_n &&
      $past(timeout_out_n) &&
      !oe && port_g_bit1_pullup_en && !halt_mode && !idle_mode;
  endsequence
  sequence s_raise;
    ##[1:3] !timeout_out_n;
  endsequence
  property p_bad_key;
    s_bad_key |-> s_raise;
  endproperty
  property p_out_low;
    port_g_bit1_pin_out == 1'h0;
  endproperty
  property p_oe_err;
    $rose(oe) |-> !timeout_out_n;
  endproperty
  property p_hold_min;
    $fell(oe) |-> low_cnt >= 16 * tc_div;
  endproperty
  property p_key_zero;
    acc && !pwrite && paddr == 12'h000 |-> prdata[5:1] == 5'h00;
  endproperty
  property p_unmapped;
    acc && !pwrite && paddr > 12'h00c |-> pslverr && prdata == 32'h0;
  endproperty
  property p_mapped;
    acc && paddr <= 12'h00c && paddr[1:0] == 2'h0 |-> pready && !pslverr;
  endproperty
  property p_reset;
    disable iff (1'b0) !presetn |-> !oe && timeout_out_n;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("no error");
  a_out_low: assert property (p_out_low) else $error("pin out");
  a_oe_err: assert property (p_oe_err) else $error("oe vs out");
  a_hold_min: assert property (p_hold_min) else $error("short");
  a_key_zero: assert property (p_key_zero) else $error("key");
  a_unmapped: assert property (p_unmapped) else $error("unmap");
  a_mapped: assert property (p_mapped) else $error("mapped");
  a_reset: assert property (p_reset) else $error("in reset");
endmodule
bind windowed_service_timer_clock_monitor service_timer_props #(
  .tc_div(tc_div)
) props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .halt_mode, .idle_mode,
  .port_g_bit1_pin_in, .port_g_bit1_pin_out, .port_g_bit1_pin_oe,
  .port_g_bit1_pullup_en, .timeout_out_n);
`default_nettype wire

/* File: error_pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module error_pin_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device pin drivers
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pullup_en,
  // Wire level and reset requests seen
  output logic pin,
  output var int reset_events
);
  logic junk;
  logic pin_q;
  // Undriven and unpulled the wire floats, shown as a toggling level
  assign pin = pin_oe ? pin_out : (pullup_en ? 1'h1 : junk);
  ////////////////////////////////////////
  // The reset circuit only listens; it never pulls the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'h1;
      junk <= 1'h0;
      reset_events <= 0;
    end else begin
      pin_q <= pin;
      junk <= ~junk;
      if (pin_q && !pin) reset_events <= reset_events + 1;
    end
  end
endmodule
`default_nettype wire

/* File: windowed_service_timer_clock_monitor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module windowed_service_timer_clock_monitor_test;
  localparam int GAP = 200;
  logic pclk = 1'h0, presetn = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, halt_mode = 1'h0, idle_mode = 1'h0;
  logic ck_pin = 1'h0, ck_run = 1'h1, m_mon = 1'h1, m_first = 1'h0;
  logic pready, pslverr, pin, pin_out, pin_oe, pull_en, tmo_n, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] m_win = 2'h3;
  logic [4:0] rk;
  int error_cnt = 0, num_checks = 0, cyc = 0, t0 = 0, n, events, exp_ev = 0;
  int seed = 32'hff07aafd;
  windowed_service_timer_clock_monitor #(.tc_div(1),
    .monitor_gap_cycles(GAP)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_mode,
    .idle_mode, .clock_input_pin(ck_pin), .port_g_bit1_pin_in(pin),
    .port_g_bit1_pin_out(pin_out), .port_g_bit1_pin_oe(pin_oe),
    .port_g_bit1_pullup_en(pull_en), .timeout_out_n(tmo_n));
  error_pin_partner partner (.pclk, .presetn, .pin_out, .pin_oe,
    .pullup_en(pull_en), .pin, .reset_events(events));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0 && ck_run) ck_pin <= ~ck_pin;
    if (cyc > 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Outputs are looked at on the falling edge, away from their updates
  task automatic wait_pin(input logic lv, input int lim);
    n = 0;
    while (tmo_n !== lv && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, m,
      input logic xe, input string what);
    apb(1'h0, a, 32'h0);
    chk(rd & m, x, what);
    chk(e, xe, what);
  endtask
  // Reference model decides the outcome before the write goes out
  task automatic service(input logic [1:0] w, input logic [4:0] k,
      input logic m);
    logic err;
    err = k !== 5'h0c;
    if (m_first) err = err || w !== m_win || m !== m_mon || cyc - t0 < 2048;
    if (!err && !m_first) begin
      m_win = w;
      m_mon = m;
      m_first = 1'h1;
    end
    apb(1'h1, 12'h000, {24'($random(seed)), w, k, m});
    t0 = cyc;
    wait_cyc(3);
    chk(tmo_n, !err, "service");
    if (err) begin
      exp_ev++;
      wait_pin(1'h1, 200);
      chk(n >= 13 && tmo_n === 1'h1, 1'h1, "hold");
      t0 = cyc;
    end
  endtask
  // Halt for 400 cycles; the model freezes or restarts its window
  task automatic halt(input logic keep);
    @(posedge pclk);
    halt_mode <= 1'h1;
    repeat (400) @(posedge pclk);
    halt_mode <= 1'h0;
    if (keep) t0 = t0 + 400;
    else t0 = cyc;
    wait_cyc(1000);
  endtask
  initial begin
    // A real falling edge, so the asynchronous reset takes hold at once
    presetn <= 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(12'h000, 32'hc1, 32'hff, 1'h0, "svc rst");
    rdchk(12'h004, 32'h00, 32'hff, 1'h0, "cfg rst");
    rdchk(12'h020, 32'h0, 32'hffffffff, 1'h1, "unmapped");
    chk(pull_en, 1'h1, "pullup");
    service(2'h0, 5'h0c, 1'h1);
    rdchk(12'h000, 32'h01, 32'hff, 1'h0, "svc");
    rdchk(12'h008, 32'h14, 32'h17, 1'h0, "status");
    wait_cyc(2100);
    service(2'h3, 5'h0c, 1'h1);
    wait_cyc(2100);
    service(2'h0, 5'h0c, 1'h0);
    wait_cyc(2100);
    service(2'h0, 5'h0c, 1'h1);
    service(2'h0, 5'h0c, 1'h1);
    wait_cyc(2100);
    rk = 5'($random(seed));
    if (rk == 5'h0c) rk = 5'h13;
    service(2'h0, rk, 1'h1);
    rdchk(12'h000, 32'h01, 32'hff, 1'h0, "svc kept");
    wait_cyc(2100);
    @(posedge pclk);
    idle_mode <= 1'h1;
    wait_cyc(50);
    @(posedge pclk);
    idle_mode <= 1'h0;
    t0 = cyc;
    service(2'h0, 5'h0c, 1'h1);
    wait_cyc(8150);
    chk(tmo_n, 1'h1, "early timeout");
    wait_pin(1'h0, 150);
    chk(tmo_n, 1'h0, "timeout");
    exp_ev++;
    wait_pin(1'h1, 200);
    t0 = cyc;
    chk(events, exp_ev, "reset events");
    @(posedge pclk);
    ck_run <= 1'h0;
    wait_cyc(GAP + 60);
    chk(tmo_n, 1'h0, "monitor fault");
    exp_ev++;
    rdchk(12'h008, 32'h02, 32'h02, 1'h0, "mon status");
    @(posedge pclk);
    ck_run <= 1'h1;
    wait_pin(1'h1, 400);
    chk(tmo_n, 1'h1, "monitor release");
    apb(1'h1, 12'h004, 32'h08);
    wait_cyc(1000);
    halt(1'h1);
    service(2'h0, 5'h0c, 1'h1);
    apb(1'h1, 12'h004, 32'h18);
    wait_cyc(1000);
    halt(1'h0);
    service(2'h0, 5'h0c, 1'h1);
    chk(events, exp_ev, "events again");
    apb(1'h1, 12'h004, 32'h04);
    wait_cyc(1);
    chk(pull_en, 1'h0, "timer off");
    end_of_test();
  end
endmodule
`default_nettype wire
